// ===== verilog/smda_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: every machine cycle is four oscillator clocks and carries one memory access; a stretched data access here takes stretch plus one cycles.
// R2: a data move is one plain fetch access followed by one stretched data access.
// R3: the stretch value 0 to 7 lives in bits 2 to 0 of the clock control register at 8Eh.
// R4: stretch zero gives a two machine cycle data move.
// R5: the data move takes the stretch value plus two machine cycles.
// R6: the strobe is 2 clocks at stretch 0 and four times the stretch value otherwise.
// R7: stretch time goes into the middle of the strobe, which stays one continuous pulse.
// R8: the first stretch step adds one clock of setup before and one of hold after the strobe.
// R9: setup and hold of address and data grow at the first stretch step, not only the pulse.
// R10: after reset the stretch value is one, a three machine cycle data move.
// R11: software may rewrite the stretch value any time and each later move uses it.
// R12: the stretch value never alters the program fetch timing.
// R13: the external memory must finish within the strobe chosen by software.
// R14: register-indirect moves take the low address from the working register and the high from port 2.
// R15: pointer moves take pointer 0 when the select bit is 0 and pointer 1 when it is 1.
// R16: the read strobe only fires on reads and the write strobe only on writes, never both.
module smda_core (
    input wire logic clock,
    input wire logic reset,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    input wire logic startReq,
    input wire smda_pkg::smda_req_t reqInfo,
    output logic startReady,
    output logic moveDone,
    output logic [7:0] readData,
    output logic readValid,
    input wire logic [7:0] memDataIn,
    output smda_pkg::smda_bus_t memBus
);
    import smda_pkg::*;

    // per-state lengths, decoded for the live and the checking logic
    function automatic logic [5:0] setupLen(input logic [2:0] s);
        setupLen = (s == 3'h0) ? SMDA_SETUP_FAST : SMDA_SETUP_SLOW;
    endfunction : setupLen

    function automatic logic [5:0] strobeLen(input logic [2:0] s);
        strobeLen = (s == 3'h0) ? SMDA_STROBE_FAST : {1'b0, s, 2'b00};
    endfunction : strobeLen

    function automatic logic [5:0] holdLen(input logic [2:0] s);
        holdLen = (s == 3'h0) ? SMDA_HOLD_FAST : SMDA_HOLD_SLOW;
    endfunction : holdLen

    logic [2:0] stretch_reg;
    logic [15:0] ptr0_reg;
    logic [15:0] ptr1_reg;
    logic select_reg;
    logic [7:0] sfrRdData_reg;
    smda_state_t state_reg;
    smda_state_t state_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [2:0] curStretch_reg;
    logic curWrite_reg;
    logic [15:0] addr_reg;
    logic [7:0] wrData_reg;
    smda_bus_t bus_reg;
    smda_bus_t bus_next;
    logic done_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [SMDA_CAPTURE_DELAY-1:0] cap_reg;
    logic [7:0] readData_reg;
    logic readValid_reg;

    // register decode
    wire wrStretch = sfrWrite && (sfrAddr == SMDA_CLOCK_CONTROL_ADDR);
    wire wrP0L = sfrWrite && (sfrAddr == SMDA_PTR0_LOW_ADDR);
    wire wrP0H = sfrWrite && (sfrAddr == SMDA_PTR0_HIGH_ADDR);
    wire wrP1L = sfrWrite && (sfrAddr == SMDA_PTR1_LOW_ADDR);
    wire wrP1H = sfrWrite && (sfrAddr == SMDA_PTR1_HIGH_ADDR);
    wire wrSel = sfrWrite && (sfrAddr == SMDA_SELECT_ADDR);
    wire [7:0] rdMux =
        (sfrAddr == SMDA_CLOCK_CONTROL_ADDR) ? {5'h00, stretch_reg} :
        (sfrAddr == SMDA_PTR0_LOW_ADDR) ? ptr0_reg[7:0] :
        (sfrAddr == SMDA_PTR0_HIGH_ADDR) ? ptr0_reg[15:8] :
        (sfrAddr == SMDA_PTR1_LOW_ADDR) ? ptr1_reg[7:0] :
        (sfrAddr == SMDA_PTR1_HIGH_ADDR) ? ptr1_reg[15:8] :
        (sfrAddr == SMDA_SELECT_ADDR) ? {7'h00, select_reg} : 8'h00;

    // clock control and pointer registers; unused bits read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            stretch_reg <= SMDA_STRETCH_RESET; // R10
            ptr0_reg <= SMDA_PTR_RESET;
            ptr1_reg <= SMDA_PTR_RESET;
            select_reg <= SMDA_SELECT_RESET;
            sfrRdData_reg <= 8'h00;
        end else begin
            if (wrStretch) stretch_reg <= sfrWrData[SMDA_STRETCH_MSB:SMDA_STRETCH_LSB]; // R3 R11
            if (wrP0L) ptr0_reg[7:0] <= sfrWrData;
            if (wrP0H) ptr0_reg[15:8] <= sfrWrData;
            if (wrP1L) ptr1_reg[7:0] <= sfrWrData;
            if (wrP1H) ptr1_reg[15:8] <= sfrWrData;
            if (wrSel) select_reg <= sfrWrData[SMDA_SELECT_BIT];
            if (sfrRead) sfrRdData_reg <= rdMux;
        end
    end

    // address source picked when the move is accepted
    wire [15:0] ptrAddr = select_reg ? ptr1_reg : ptr0_reg; // R15
    wire [15:0] regAddr = {reqInfo.port2Latch, reqInfo.workReg}; // R14
    wire [15:0] startAddr = reqInfo.usePointer ? ptrAddr : regAddr;
    wire accept = startReq && (state_reg == SMDA_IDLE);

    // length of the current state; fetch ignores the stretch value
    wire [5:0] stateLen =
        (state_reg == SMDA_FETCH) ? SMDA_CLOCKS_PER_MC : // R1 R12
        (state_reg == SMDA_SETUP) ? setupLen(curStretch_reg) : // R8 R9
        (state_reg == SMDA_STROBE) ? strobeLen(curStretch_reg) : // R6 R7
        (state_reg == SMDA_HOLD) ? holdLen(curStretch_reg) : 6'h01; // R8 R9
    wire lastClk = (cnt_reg == stateLen - 6'h01);

    // sequencer: fetch, then setup, one strobe run, hold
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 6'h01;
        case (state_reg)
            SMDA_IDLE: begin
                cnt_next = 6'h00;
                if (accept) state_next = SMDA_FETCH; // R2
            end
            SMDA_FETCH: begin
                if (lastClk) state_next = SMDA_SETUP;
            end
            SMDA_SETUP: begin
                if (lastClk) state_next = SMDA_STROBE;
            end
            SMDA_STROBE: begin
                if (lastClk) state_next = SMDA_HOLD;
            end
            SMDA_HOLD: begin
                if (lastClk) state_next = SMDA_IDLE;
            end
            default: begin
                state_next = SMDA_IDLE;
            end
        endcase
        if (state_next != state_reg) cnt_next = 6'h00;
    end

    // pins follow the next state so they line up with state_reg
    wire inStrobe = (state_next == SMDA_STROBE);
    wire inData = (state_next == SMDA_SETUP) || inStrobe || (state_next == SMDA_HOLD);
    wire nxtWrite = accept ? reqInfo.write : curWrite_reg;
    always_comb begin
        bus_next.readN = !(inStrobe && !nxtWrite); // R16
        bus_next.writeN = !(inStrobe && nxtWrite); // R16
        bus_next.fetchN = !((state_next == SMDA_FETCH) && (cnt_next >= SMDA_FETCH_STROBE_FIRST)
            && (cnt_next <= SMDA_FETCH_STROBE_LAST));
        bus_next.dataEn = inData && nxtWrite; // R9
        bus_next.addr = accept ? startAddr : addr_reg;
        bus_next.data = accept ? reqInfo.writeData : wrData_reg;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= SMDA_IDLE;
            cnt_reg <= 6'h00;
            curStretch_reg <= SMDA_STRETCH_RESET;
            curWrite_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wrData_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= (state_reg == SMDA_HOLD) && lastClk; // R5
            if (accept) begin
                curStretch_reg <= stretch_reg; // R11
                curWrite_reg <= reqInfo.write;
                addr_reg <= startAddr;
                wrData_reg <= reqInfo.writeData;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bus_reg <= '{readN: 1'b1, writeN: 1'b1, fetchN: 1'b1, dataEn: 1'b0, addr: 16'h0000, data: 8'h00};
        end else begin
            bus_reg <= bus_next;
        end
    end

    // read data: three flops deep since the bus is asynchronous to us;
    // the sample is the value present in the strobe's last clock
    wire strobeEnd = (state_reg == SMDA_STROBE) && lastClk && !curWrite_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            sync3_reg <= 8'h00;
            cap_reg <= '0;
            readData_reg <= 8'h00;
            readValid_reg <= 1'b0;
        end else begin
            sync1_reg <= memDataIn;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            cap_reg <= {cap_reg[SMDA_CAPTURE_DELAY-2:0], strobeEnd};
            readValid_reg <= cap_reg[SMDA_CAPTURE_DELAY-1];
            if (cap_reg[SMDA_CAPTURE_DELAY-1]) readData_reg <= sync3_reg;
        end
    end

    assign sfrRdData = sfrRdData_reg;
    assign startReady = (state_reg == SMDA_IDLE);
    assign moveDone = done_reg;
    assign readData = readData_reg;
    assign readValid = readValid_reg;
    assign memBus = bus_reg;

    // checking helpers: run lengths of the strobe and of the whole move
    logic [5:0] strobeRun_reg;
    logic [5:0] accessRun_reg;
    wire strobeLow = !memBus.readN || !memBus.writeN;
    always_ff @(posedge clock) begin
        if (reset) begin
            strobeRun_reg <= 6'h00;
            accessRun_reg <= 6'h00;
        end else begin
            strobeRun_reg <= strobeLow ? strobeRun_reg + 6'h01 : 6'h00;
            accessRun_reg <= (state_reg != SMDA_IDLE) ? accessRun_reg + 6'h01 : 6'h00;
        end
    end

    property p_one_strobe;
        @(posedge clock) disable iff (reset) !(!memBus.readN && !memBus.writeN);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low"); // R16

    property p_strobe_kind;
        @(posedge clock) disable iff (reset) strobeLow |-> (memBus.writeN == !curWrite_reg);
    endproperty
    a_strobe_kind: assert property (p_strobe_kind) else $error("wrong strobe for direction"); // R16

    property p_strobe_width;
        @(posedge clock) disable iff (reset)
            $fell(strobeLow) |-> (strobeRun_reg == strobeLen(curStretch_reg));
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong"); // R6 R7

    property p_total_cycles;
        @(posedge clock) disable iff (reset)
            moveDone |-> (accessRun_reg == ({3'h0, curStretch_reg} + 6'h02) * SMDA_CLOCKS_PER_MC);
    endproperty
    a_total_cycles: assert property (p_total_cycles) else $error("move length wrong"); // R1 R4 R5

    property p_setup_before;
        @(posedge clock) disable iff (reset)
            $rose(state_reg == SMDA_STROBE) |-> ($past(cnt_reg) == setupLen(curStretch_reg) - 6'h01);
    endproperty
    a_setup_before: assert property (p_setup_before) else $error("setup length wrong"); // R8

    property p_hold_after;
        @(posedge clock) disable iff (reset)
            ($fell(strobeLow) && curWrite_reg) |-> memBus.dataEn ##1 (memBus.dataEn == (curStretch_reg != 3'h0));
    endproperty
    a_hold_after: assert property (p_hold_after) else $error("data hold wrong"); // R8 R9

    property p_addr_steady;
        @(posedge clock) disable iff (reset)
            (strobeLow && $past(strobeLow)) |-> $stable(memBus.addr);
    endproperty
    a_addr_steady: assert property (p_addr_steady) else $error("address moved in strobe"); // R9

    property p_fetch_fixed;
        @(posedge clock) disable iff (reset)
            accept |=> (state_reg == SMDA_FETCH)[*4] ##1 (state_reg == SMDA_SETUP);
    endproperty
    a_fetch_fixed: assert property (p_fetch_fixed) else $error("fetch not one machine cycle"); // R2 R12

    property p_reset_default;
        @(posedge clock) reset |=> (stretch_reg == 3'h1);
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("stretch reset not one"); // R10

    property p_stretch_write;
        @(posedge clock) disable iff (reset)
            wrStretch |=> (stretch_reg == $past(sfrWrData[2:0]));
    endproperty
    a_stretch_write: assert property (p_stretch_write) else $error("stretch write lost"); // R3 R11

    property p_pointer_pick;
        @(posedge clock) disable iff (reset)
            (accept && reqInfo.usePointer) |=> (memBus.addr == ($past(select_reg) ? $past(ptr1_reg) : $past(ptr0_reg)));
    endproperty
    a_pointer_pick: assert property (p_pointer_pick) else $error("wrong pointer used"); // R15

    property p_indirect_addr;
        @(posedge clock) disable iff (reset)
            (accept && !reqInfo.usePointer) |=> (memBus.addr == $past(regAddr));
    endproperty
    a_indirect_addr: assert property (p_indirect_addr) else $error("indirect address wrong"); // R14
endmodule : smda_core

// ===== verilog/smda_pkg.sv
package smda_pkg;
    // special register locations
    localparam logic [7:0] SMDA_PTR0_LOW_ADDR = 8'h82;
    localparam logic [7:0] SMDA_PTR0_HIGH_ADDR = 8'h83;
    localparam logic [7:0] SMDA_PTR1_LOW_ADDR = 8'h84;
    localparam logic [7:0] SMDA_PTR1_HIGH_ADDR = 8'h85;
    localparam logic [7:0] SMDA_SELECT_ADDR = 8'h86;
    localparam logic [7:0] SMDA_CLOCK_CONTROL_ADDR = 8'h8e;
    // field positions and reset values
    localparam int SMDA_STRETCH_LSB = 0;
    localparam int SMDA_STRETCH_MSB = 2;
    localparam int SMDA_SELECT_BIT = 0;
    localparam logic [2:0] SMDA_STRETCH_RESET = 3'h1;
    localparam logic [15:0] SMDA_PTR_RESET = 16'h0000;
    localparam logic SMDA_SELECT_RESET = 1'b0;
    // timing counts in oscillator clocks
    localparam logic [5:0] SMDA_CLOCKS_PER_MC = 6'h04;
    localparam logic [5:0] SMDA_SETUP_FAST = 6'h01;
    localparam logic [5:0] SMDA_SETUP_SLOW = 6'h02;
    localparam logic [5:0] SMDA_STROBE_FAST = 6'h02;
    localparam logic [5:0] SMDA_HOLD_FAST = 6'h01;
    localparam logic [5:0] SMDA_HOLD_SLOW = 6'h02;
    localparam logic [5:0] SMDA_FETCH_STROBE_FIRST = 6'h01;
    localparam logic [5:0] SMDA_FETCH_STROBE_LAST = 6'h02;
    localparam int SMDA_CAPTURE_DELAY = 3;

    typedef enum logic [2:0] {
        SMDA_IDLE = 3'b000,
        SMDA_FETCH = 3'b001,
        SMDA_SETUP = 3'b011,
        SMDA_STROBE = 3'b010,
        SMDA_HOLD = 3'b110
    } smda_state_t;

    typedef struct packed {
        logic write;
        logic usePointer;
        logic [7:0] workReg;
        logic [7:0] port2Latch;
        logic [7:0] writeData;
    } smda_req_t;

    typedef struct packed {
        logic readN;
        logic writeN;
        logic fetchN;
        logic dataEn;
        logic [15:0] addr;
        logic [7:0] data;
    } smda_bus_t;
endpackage : smda_pkg

// ===== verification/smda_mem_model.sv
`timescale 1ns/1ps
// behavioural sram on the external bus, prompt or slow to answer reads
module smda_mem_model (
    input wire logic clock,
    input wire logic slow,
    input wire smda_pkg::smda_bus_t memBus,
    output logic [7:0] memDataIn
);
    import smda_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'h5a;
    logic [1:0] lowCnt = 2'h0;
    logic ready;
    // slow part needs three strobe clocks first; undriven bus toggles, never holds the last byte
    assign ready = !memBus.readN && (!slow || lowCnt == 2'h3);
    assign memDataIn = ready ? mem[memBus.addr] : junk;
    // writes land on every clock the write strobe is low with data driven
    always @(posedge clock) begin
        junk <= ~junk;
        lowCnt <= memBus.readN ? 2'h0 : (lowCnt == 2'h3 ? lowCnt : lowCnt + 2'h1);
        if (!memBus.writeN && memBus.dataEn) begin
            mem[memBus.addr] <= memBus.data;
        end
    end
endmodule : smda_mem_model

// ===== verification/tb_stretched_data_memory_access.sv
`timescale 1ns/1ps
module tb_stretched_data_memory_access;
    import smda_pkg::*;
    typedef struct packed {
        logic [5:0] busy;
        logic [5:0] width;
        logic [5:0] first;
        logic [5:0] gap;
        logic write;
        logic [15:0] addr;
    } smda_exp_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic startReq = 1'b0;
    logic slow = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData, readData, memDataIn;
    logic startReady, moveDone, readValid, enSeen;
    logic sfrRdPend = 1'b0;
    logic [15:0] addrSeen;
    smda_req_t reqInfo = '0;
    smda_bus_t memBus;
    int failures = 0;
    int tests_run = 0;
    int seed = 32'hb660;
    int cyc, busy, rdw, wrw, fetch, first, last;
    smda_exp_t expQ[$];
    smda_exp_t e;
    logic [7:0] datQ[$];
    logic [7:0] sfrQ[$];

    smda_core smda_core_i (.clock(clock), .reset(reset), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
        .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .startReq(startReq),
        .reqInfo(reqInfo), .startReady(startReady), .moveDone(moveDone), .readData(readData),
        .readValid(readValid), .memDataIn(memDataIn), .memBus(memBus));
    smda_mem_model smda_mem_model_i (.clock(clock), .slow(slow), .memBus(memBus), .memDataIn(memDataIn));

    initial begin
        forever #10 clock = ~clock;
    end

    task chk(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : chk

    task end_sim;
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // one-clock register strobe; a read notes the byte it should return
    task sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        if (!wr) sfrQ.push_back(d);
        sfrWrite = wr;
        sfrRead = !wr;
        sfrAddr = a;
        sfrWrData = d;
        @(negedge clock);
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
    endtask : sfr

    // start one move, note its expected shape, wait bounded for completion
    task move(input smda_req_t r, input int s, input logic [15:0] a);
        int n;
        @(negedge clock);
        startReq = 1'b1;
        reqInfo = r;
        expQ.push_back('{6'(4 * (s + 2)), 6'(s == 0 ? 2 : 4 * s), 6'(s == 0 ? 6 : 7), 6'(s == 0 ? 2 : 3), r.write, a});
        if (!r.write) datQ.push_back(r.writeData);
        @(negedge clock);
        startReq = 1'b0;
        n = 0;
        while (!moveDone && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n == 400) begin
            failures++;
            end_sim();
        end
    endtask : move

    // write a random byte by register-indirect, read it back by the selected pointer
    task pair(input int s, input logic sel);
        logic [15:0] a;
        logic [7:0] d;
        a = 16'($random(seed));
        d = 8'($random(seed));
        sfr(1'b1, sel ? SMDA_PTR1_LOW_ADDR : SMDA_PTR0_LOW_ADDR, a[7:0]);
        sfr(1'b1, sel ? SMDA_PTR1_HIGH_ADDR : SMDA_PTR0_HIGH_ADDR, a[15:8]);
        sfr(1'b1, sel ? SMDA_PTR0_LOW_ADDR : SMDA_PTR1_LOW_ADDR, ~a[7:0]);
        sfr(1'b1, SMDA_SELECT_ADDR, {7'h2a, sel});
        slow = (s != 0);
        move('{1'b1, 1'b0, a[7:0], a[15:8], d}, s, a);
        move('{1'b0, 1'b1, ~a[7:0], ~a[15:8], d}, s, a);
    endtask : pair

    // watcher: measures each move against the oldest note
    always @(posedge clock) begin
        if (!reset) begin
            cyc++;
            if (!startReady) busy++;
            if (!memBus.fetchN) fetch++;
            if (!memBus.readN) rdw++;
            if (!memBus.writeN) wrw++;
            if ((!memBus.readN || !memBus.writeN) && first == 0) begin
                first = cyc;
                addrSeen = memBus.addr;
                enSeen = memBus.dataEn;
            end
            if (!memBus.readN || !memBus.writeN) last = cyc;
            if (moveDone && expQ.size() > 0) begin
                e = expQ.pop_front();
                chk(busy, e.busy);
                chk(e.write ? wrw : rdw, e.width);
                chk(e.write ? rdw : wrw, 0);
                chk(last - first + 1, e.width);
                chk(first, e.first);
                chk(cyc - last, e.gap);
                chk(fetch, 2);
                chk(addrSeen, e.addr);
                chk(enSeen, e.write);
            end
            if (readValid) chk(readData, datQ.pop_front());
            if (sfrRdPend) chk(sfrRdData, sfrQ.pop_front());
            sfrRdPend = sfrRead;
            if (startReq && startReady) begin
                cyc = 0;
                busy = 0;
                fetch = 0;
                rdw = 0;
                wrw = 0;
                first = 0;
                last = 0;
            end
        end
    end

    // main sequence: defaults, every stretch value, field masking, unmapped read
    initial begin
        repeat (4) @(negedge clock);
        reset = 1'b0;
        sfr(1'b0, SMDA_CLOCK_CONTROL_ADDR, 8'h01);
        sfr(1'b0, SMDA_SELECT_ADDR, 8'h00);
        pair(1, 1'b0);
        for (int s = 0; s < 8; s++) begin
            sfr(1'b1, SMDA_CLOCK_CONTROL_ADDR, {5'($random(seed)), 3'(s)});
            pair(s, s[0]);
        end
        // stretch rewritten mid-move: that move keeps seven, the next one runs at zero
        slow = 1'b0;
        fork
            move('{1'b1, 1'b0, 8'h10, 8'h20, 8'h3c}, 7, 16'h2010);
            begin
                repeat (3) @(negedge clock);
                sfr(1'b1, SMDA_CLOCK_CONTROL_ADDR, 8'h00);
            end
        join
        move('{1'b0, 1'b0, 8'h10, 8'h20, 8'h3c}, 0, 16'h2010);
        sfr(1'b1, SMDA_CLOCK_CONTROL_ADDR, 8'hff);
        sfr(1'b0, SMDA_CLOCK_CONTROL_ADDR, 8'h07);
        sfr(1'b1, SMDA_SELECT_ADDR, 8'hff);
        sfr(1'b0, SMDA_SELECT_ADDR, 8'h01);
        sfr(1'b0, 8'h90, 8'h00);
        repeat (10) @(negedge clock);
        chk(datQ.size() + expQ.size(), 0);
        end_sim();
    end
endmodule : tb_stretched_data_memory_access
